// >>> bench/frt_ext_clock_model.sv
module frt_ext_clock_model (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Control
  input wire logic run,
  // External clock pins
  output logic [2:0] ext_clock
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] phase_reg;
  // ----------------------------------------------------------------
  // Pulse source: high and low for 2 cycles each, parked low when halted
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst || !run) begin
      phase_reg <= 5'h00;
    end else begin
      phase_reg <= phase_reg + 5'h01;
    end
  end
  assign ext_clock = {3{phase_reg[1]}};
endmodule

// >>> bench/frt_timer_tb_top.sv
module frt_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic run = 1'b0;
  logic [2:0] ext_clock;
  logic [2:0] compare_out_a;
  logic [2:0] compare_out_b;
  int bad_count = 0;
  int compares = 0;
  logic [31:0] r [3];
  logic [31:0] v;
  int div [3] = '{4, 8, 32};
  logic [1:0] sel [3] = '{frt_pkg::CKS_DIV4, frt_pkg::CKS_DIV8, frt_pkg::CKS_DIV32};
  always #20 clk = ~clk;
  frt_timer dut (.clk(clk), .srst(srst), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .ext_clock(ext_clock), .compare_out_a(compare_out_a), .compare_out_b(compare_out_b));
  frt_ext_clock_model ext_model (.clk(clk), .srst(srst), .run(run), .ext_clock(ext_clock));
  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [2:0] sz,
                     input logic [31:0] wd, output logic [31:0] rd);
    haddr <= a;
    hwrite <= wr;
    hsize <= sz;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    ahb(1'b1, a, frt_pkg::HSIZE_WORD, d, dummy);
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    ahb(1'b0, a, frt_pkg::HSIZE_WORD, 32'h0, d);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    report_and_stop;
  end
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (int c = 0; c < 3; c++) begin
      rd(32'h10 * c, r[c]);
      idle(2);
    end
    chk("reset sync ch1", r[0] + 32'h1, r[1]);
    chk("reset sync ch2", r[0] + 32'h2, r[2]);
    rd(32'h4, v);
    chk("compare a reset", 32'h0000ffff, v);
    rd(32'hc, v);
    chk("control reset", 32'h0, v);
    wr(32'h30, 32'h1234);
    rd(32'h30, v);
    chk("unmapped", 32'h0, v);
    for (int s = 0; s < 3; s++) begin
      for (int c = 0; c < 3; c++) wr(32'h10 * c + 32'hc, {30'h0, sel[s]});
      for (int c = 0; c < 3; c++) begin
        wr(32'h10 * c, 32'h1000 + c);
        if (c < 2) idle(div[s] - 2);
      end
      idle(div[s]);
      for (int c = 0; c < 3; c++) begin
        rd(32'h10 * c, r[c]);
        if (c < 2) idle(div[s] - 2);
      end
      chk("sync diff ch1", r[0] + 32'h1, r[1]);
      chk("sync diff ch2", r[0] + 32'h2, r[2]);
    end
    wr(32'hc, 32'h0);
    wr(32'h0, 32'hffff);
    idle(8);
    rd(32'hc, v);
    chk("wrap flags", 32'he0, v);
    wr(32'hc, 32'he0);
    rd(32'hc, v);
    chk("flags cleared", 32'h0, v);
    wr(32'h14, 32'h5);
    wr(32'h1c, 32'h0c);
    wr(32'h10, 32'h0);
    idle(40);
    rd(32'h1c, v);
    chk("match a flag", 32'h4c, v);
    chk("match a pin", 32'h1, {31'h0, compare_out_a[1]});
    rd(32'h10, v);
    chk("clear on match", 32'h1, {31'h0, v < 32'h6});
    wr(32'h1c, 32'h44);
    idle(40);
    chk("match a pin low", 32'h0, {31'h0, compare_out_a[1]});
    ahb(1'b1, 32'h29, frt_pkg::HSIZE_BYTE, 32'h1200, v);
    rd(32'h28, v);
    chk("staged not live", 32'h0000ffff, v);
    ahb(1'b1, 32'h28, frt_pkg::HSIZE_BYTE, 32'h34, v);
    rd(32'h28, v);
    chk("staged commit", 32'h1234, v);
    chk("compare b pins", 32'h0, {29'h0, compare_out_b});
    // Writes swept over every prescaler phase, 16 cycles a pass
    wr(32'h4, 32'h0040);
    for (int k = 0; k < 14; k++) begin
      wr(32'hc, 32'h44);
      wr(32'h0, 32'h003f);
      idle(k % 7);
      if (k < 7) wr(32'h0, 32'h0055);
      else wr(32'h4, 32'h0040);
      idle(10 - k % 7);
    end
    rd(32'h4, v);
    chk("compare write kept", 32'h40, v);
    for (int k = 0; k < 8; k++) begin
      wr(32'hc, {30'h0, frt_pkg::CKS_DIV4});
      idle(k);
      wr(32'hc, {30'h0, frt_pkg::CKS_DIV8});
      idle(12 - k);
    end
    for (int c = 0; c < 3; c++) wr(32'h10 * c + 32'hc, {30'h0, frt_pkg::CKS_EXT});
    for (int c = 0; c < 3; c++) wr(32'h10 * c, 32'h0100);
    run <= 1'b1;
    idle(16);
    run <= 1'b0;
    idle(4);
    for (int c = 0; c < 3; c++) begin
      rd(32'h10 * c, v);
      chk("external count", 32'h0104, v);
    end
    report_and_stop;
  end
endmodule

// >>> hw/frt_ahb_front.sv
module frt_ahb_front (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Address phase
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  // Decoded transfer
  output logic acc,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [2:0] wr_size
);
  // ---------------------------------------------------------------
  // Address phase accept and data phase capture
  // ---------------------------------------------------------------
  assign acc = hsel & htrans[frt_pkg::HTRANS_NONSEQ_BIT] & hready;

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_en <= 1'b0;
      wr_addr <= 8'h00;
      wr_size <= 3'h0;
    end else if (ce) begin
      wr_en <= acc & hwrite;
      if (acc) begin
        wr_addr <= haddr[7:0];
        wr_size <= hsize;
      end
    end
  end
endmodule

// >>> hw/frt_timer.sv
// Summary of operation
// - Counter clear in the committing write cycle wins; the write is lost.
// - Increment in the committing write cycle is dropped; written value loads.
// - Compare write cycle suppresses that cycle's compare-match event.
// - Increment pulse comes from falling edge of selected prescaled clock.
// - Select change from high old source to low new source increments once.
// - Internal/external switch may also increment once, same edge detector.
// - Each channel offers divide-by-4, 8 and 32 internal sources.
// - Overflow flag sets when counter wraps from all ones to zero.
// - Compare-match occurs in last equal cycle, just before counter advances.
// - High byte is staged, committed with low byte as one 16-bit update.
// - After reset all channels run in step on divide-by-4.
module frt_timer (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Timer pins
  input wire logic [2:0] ext_clock,
  output logic [2:0] compare_out_a,
  output logic [2:0] compare_out_b
);
  localparam int N = frt_pkg::NUM_CH;

  logic acc;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [2:0] wr_size;
  logic [4:0] div_reg;
  logic [15:0] cnt_reg [N];
  logic [15:0] cmpa_reg [N];
  logic [15:0] cmpb_reg [N];
  logic [7:0] stage_reg [N];
  logic [1:0] cks_reg [N];
  logic [N-1:0] clr_en_reg, lvl_a_reg, lvl_b_reg, ovf_reg, flag_a_reg, flag_b_reg;
  logic [N-1:0] prev_reg;
  logic [N-1:0] lvl, inc, evt_a, evt_b, clr, wcnt, wcmpa, wcmpb, wctl, wstage;
  logic commit, stage_lane;
  logic [15:0] wval [N];
  logic [31:0] rd_word;

  frt_ahb_front u_front (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .acc(acc),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_size(wr_size)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input int ch, input logic [3:0] off);
    hit = (a[7:4] == 4'(ch)) && (a[3:2] == off[3:2]);
  endfunction

  // Level whose falling edge makes one increment; external rising edge is inverted
  function automatic logic tick_level(input logic [1:0] cks, input logic [4:0] dv,
                                      input logic ext);
    case (cks)
      frt_pkg::CKS_DIV4: tick_level = dv[frt_pkg::DIV4_BIT];
      frt_pkg::CKS_DIV8: tick_level = dv[frt_pkg::DIV8_BIT];
      frt_pkg::CKS_DIV32: tick_level = dv[frt_pkg::DIV32_BIT];
      default: tick_level = ~ext;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Shared prescaler
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      div_reg <= frt_pkg::RST_DIVIDER;
    end else if (ce) begin
      div_reg <= div_reg + 5'h01;
    end
  end

  // ---------------------------------------------------------------
  // Per-channel events and write decode
  // ---------------------------------------------------------------
  always_comb begin
    commit = (wr_size == frt_pkg::HSIZE_WORD)
          || (wr_size == frt_pkg::HSIZE_HALF && !wr_addr[1])
          || (wr_size == frt_pkg::HSIZE_BYTE && wr_addr[1:0] == 2'h0);
    stage_lane = (wr_size == frt_pkg::HSIZE_BYTE) && (wr_addr[1:0] == 2'h1);
    for (int i = 0; i < N; i++) begin
      lvl[i] = tick_level(cks_reg[i], div_reg, ext_clock[i]);
      inc[i] = prev_reg[i] & ~lvl[i];
      wcnt[i] = wr_en & commit & hit(wr_addr, i, frt_pkg::OFF_COUNTER);
      wcmpa[i] = wr_en & commit & hit(wr_addr, i, frt_pkg::OFF_COMPARE_A);
      wcmpb[i] = wr_en & commit & hit(wr_addr, i, frt_pkg::OFF_COMPARE_B);
      wctl[i] = wr_en & commit & hit(wr_addr, i, frt_pkg::OFF_CONTROL);
      wstage[i] = wr_en & stage_lane & (wr_addr[3:2] != 2'h3) && (wr_addr[7:4] == 4'(i));
      wval[i] = (wr_size == frt_pkg::HSIZE_BYTE) ? {stage_reg[i], hwdata[7:0]}
                                                 : hwdata[15:0];
      evt_a[i] = inc[i] & (cnt_reg[i] == cmpa_reg[i]) & ~wcmpa[i];
      evt_b[i] = inc[i] & (cnt_reg[i] == cmpb_reg[i]) & ~wcmpb[i];
      clr[i] = evt_a[i] & clr_en_reg[i];
    end
  end

  // ---------------------------------------------------------------
  // Counters, staging byte and edge history
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < N; i++) begin
        cnt_reg[i] <= frt_pkg::RST_COUNTER;
        stage_reg[i] <= 8'h00;
      end
      prev_reg <= '0;
    end else if (ce) begin
      for (int i = 0; i < N; i++) begin
        prev_reg[i] <= lvl[i];
        if (wstage[i]) begin
          stage_reg[i] <= hwdata[15:8];
        end
        if (clr[i]) begin
          cnt_reg[i] <= frt_pkg::RST_COUNTER;
        end else if (wcnt[i]) begin
          cnt_reg[i] <= wval[i];
        end else if (inc[i]) begin
          cnt_reg[i] <= cnt_reg[i] + 16'h0001;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Compare values and control
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < N; i++) begin
        cmpa_reg[i] <= frt_pkg::RST_COMPARE;
        cmpb_reg[i] <= frt_pkg::RST_COMPARE;
        cks_reg[i] <= frt_pkg::RST_CKS;
      end
      clr_en_reg <= '0;
      lvl_a_reg <= '0;
      lvl_b_reg <= '0;
    end else if (ce) begin
      for (int i = 0; i < N; i++) begin
        if (wcmpa[i]) begin
          cmpa_reg[i] <= wval[i];
        end
        if (wcmpb[i]) begin
          cmpb_reg[i] <= wval[i];
        end
        if (wctl[i]) begin
          cks_reg[i] <= hwdata[1:0];
          clr_en_reg[i] <= hwdata[frt_pkg::BIT_CLEAR_ON_MATCH_A];
          lvl_a_reg[i] <= hwdata[frt_pkg::BIT_OUTPUT_LEVEL_A];
          lvl_b_reg[i] <= hwdata[frt_pkg::BIT_OUTPUT_LEVEL_B];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Sticky flags and compare outputs: write one clears a flag, a new event wins
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      compare_out_a <= '0;
      compare_out_b <= '0;
      ovf_reg <= '0;
      flag_a_reg <= '0;
      flag_b_reg <= '0;
    end else if (ce) begin
      for (int i = 0; i < N; i++) begin
        if (inc[i] && cnt_reg[i] == frt_pkg::COUNTER_MAX && !wcnt[i] && !clr[i]) begin
          ovf_reg[i] <= 1'b1;
        end else if (wctl[i] && hwdata[frt_pkg::BIT_OVERFLOW]) begin
          ovf_reg[i] <= 1'b0;
        end
        if (evt_a[i]) begin
          flag_a_reg[i] <= 1'b1;
          compare_out_a[i] <= lvl_a_reg[i];
        end else if (wctl[i] && hwdata[frt_pkg::BIT_FLAG_A]) begin
          flag_a_reg[i] <= 1'b0;
        end
        if (evt_b[i]) begin
          flag_b_reg[i] <= 1'b1;
          compare_out_b[i] <= lvl_b_reg[i];
        end else if (wctl[i] && hwdata[frt_pkg::BIT_FLAG_B]) begin
          flag_b_reg[i] <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Read path: zero wait states, unmapped reads return zero
  // ---------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0000_0000;
    for (int i = 0; i < N; i++) begin
      if (hit(haddr[7:0], i, frt_pkg::OFF_COUNTER)) begin
        rd_word = {16'h0000, cnt_reg[i]};
      end else if (hit(haddr[7:0], i, frt_pkg::OFF_COMPARE_A)) begin
        rd_word = {16'h0000, cmpa_reg[i]};
      end else if (hit(haddr[7:0], i, frt_pkg::OFF_COMPARE_B)) begin
        rd_word = {16'h0000, cmpb_reg[i]};
      end else if (hit(haddr[7:0], i, frt_pkg::OFF_CONTROL)) begin
        rd_word = {24'h000000, flag_b_reg[i], flag_a_reg[i], ovf_reg[i], lvl_b_reg[i],
                   lvl_a_reg[i], clr_en_reg[i], cks_reg[i]};
      end
    end
    if (haddr[31:8] != 24'h000000) begin
      rd_word = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (acc && !hwrite) begin
        hrdata <= rd_word;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks, mostly on channel 0
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_clear_beats_write: assert property (
    ce && wcnt[0] && clr[0] |=> cnt_reg[0] == 16'h0000)
    else $error("counter write was not overridden by clear");
  a_write_beats_inc: assert property (
    ce && wcnt[0] && inc[0] && !clr[0] |=> cnt_reg[0] == $past(wval[0]))
    else $error("increment disturbed counter write");
  a_cmp_write_blocks: assert property (
    ce && wcmpa[0] && inc[0] && cnt_reg[0] == cmpa_reg[0] && !flag_a_reg[0]
      |=> !flag_a_reg[0])
    else $error("compare match not suppressed by compare write");
  a_fall_increments: assert property (
    ce && cks_reg[0] != frt_pkg::CKS_EXT && $fell(lvl[0]) && $past(ce) && !wcnt[0]
      && !clr[0] |=> cnt_reg[0] == $past(cnt_reg[0]) + 16'h0001)
    else $error("falling edge of prescaled clock did not increment");
  a_switch_increment: assert property (
    ce && $changed(cks_reg[0]) && $past(ce) && prev_reg[0] && !lvl[0] && !wcnt[0]
      && !clr[0] |=> cnt_reg[0] == $past(cnt_reg[0]) + 16'h0001)
    else $error("clock select changeover did not increment");
  a_overflow_sets: assert property (
    ce && inc[0] && cnt_reg[0] == 16'hffff && !wcnt[0] && !clr[0]
      |=> ovf_reg[0] && cnt_reg[0] == 16'h0000)
    else $error("wrap did not set overflow flag");
  a_match_timing: assert property (
    ce && inc[0] && cnt_reg[0] == cmpa_reg[0] && !wcmpa[0]
      |=> flag_a_reg[0] && compare_out_a[0] == $past(lvl_a_reg[0]))
    else $error("compare match flag or output missing");
  a_stage_commit: assert property (
    ce && wcmpb[2] && wr_size == frt_pkg::HSIZE_BYTE
      |=> cmpb_reg[2] == {$past(stage_reg[2]), $past(hwdata[7:0])})
    else $error("staged high byte not committed with low byte");
  a_reset_div4: assert property (
    $past(srst) |-> cks_reg[0] == frt_pkg::CKS_DIV4 && cks_reg[1] == frt_pkg::CKS_DIV4)
    else $error("channels not on divide-by-4 after reset");
endmodule

// >>> shared/frt_pkg.sv
package frt_pkg;
  // ---------------------------------------------------------------
  // Register map: one 16-byte window per channel
  // ---------------------------------------------------------------
  localparam int NUM_CH = 3;
  localparam logic [7:0] CH_STRIDE = 8'h10;
  localparam logic [3:0] OFF_COUNTER = 4'h0;
  localparam logic [3:0] OFF_COMPARE_A = 4'h4;
  localparam logic [3:0] OFF_COMPARE_B = 4'h8;
  localparam logic [3:0] OFF_CONTROL = 4'hc;
  // ---------------------------------------------------------------
  // Control/status field positions
  // ---------------------------------------------------------------
  localparam int BIT_CLEAR_ON_MATCH_A = 2;
  localparam int BIT_OUTPUT_LEVEL_A = 3;
  localparam int BIT_OUTPUT_LEVEL_B = 4;
  localparam int BIT_OVERFLOW = 5;
  localparam int BIT_FLAG_A = 6;
  localparam int BIT_FLAG_B = 7;
  // ---------------------------------------------------------------
  // Clock select encodings and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] CKS_DIV4 = 2'h0;
  localparam logic [1:0] CKS_DIV8 = 2'h1;
  localparam logic [1:0] CKS_DIV32 = 2'h2;
  localparam logic [1:0] CKS_EXT = 2'h3;
  localparam logic [1:0] RST_CKS = CKS_DIV4;
  localparam logic [15:0] RST_COUNTER = 16'h0000;
  localparam logic [15:0] RST_COMPARE = 16'hffff;
  localparam logic [15:0] COUNTER_MAX = 16'hffff;
  localparam logic [4:0] RST_DIVIDER = 5'h00;
  // Divider bit that carries each prescaled clock
  localparam int DIV4_BIT = 1;
  localparam int DIV8_BIT = 2;
  localparam int DIV32_BIT = 4;
  // ---------------------------------------------------------------
  // AHB-Lite encodings
  // ---------------------------------------------------------------
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_HALF = 3'h1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int HTRANS_NONSEQ_BIT = 1;
endpackage
